/* File: hdl/general_io_ports_regs.vh */
// register offsets, reset values and field layout of the general I/O ports
`ifndef GENERAL_IO_PORTS_REGS_VH
`define GENERAL_IO_PORTS_REGS_VH

// 8-bit register indices; byte address is four times the index
`define IDX_DATA_A       8'h00
`define IDX_DATA_B       8'h01
`define IDX_DATA_C       8'h02
`define IDX_DATA_D       8'h05
`define IDX_DATA_E       8'h06
`define IDX_DIR_A        8'h20
`define IDX_DIR_B        8'h21
`define IDX_DIR_C        8'h22
`define IDX_DIR_D        8'h25
`define IDX_PULL_C       8'h32
`define IDX_PULL_AB      8'hF7

`define ADDR_DATA_A      12'h000
`define ADDR_DATA_B      12'h004
`define ADDR_DATA_C      12'h008
`define ADDR_DATA_D      12'h014
`define ADDR_DATA_E      12'h018
`define ADDR_DIR_A       12'h080
`define ADDR_DIR_B       12'h084
`define ADDR_DIR_C       12'h088
`define ADDR_DIR_D       12'h094
`define ADDR_PULL_C      12'h0C8
`define ADDR_PULL_AB     12'h3DC

// reset values
`define DIR_RESET        8'hFF
`define PULL_RESET       8'h00
`define LATCH_RESET      8'h00

// pull-up select bits for the shared register
`define PULL_AB_BIT_A    0
`define PULL_AB_BIT_B    1

`endif

/* File: hdl/pin_sync.v */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             nrst,
    // pins in, synchronised out
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] pinSync
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign pinSync = stage2_reg;
endmodule // pin_sync
`default_nettype wire

/* File: hdl/io_port_bit.v */
// one bidirectional port bit: drive and pull-up decision, registered
`timescale 1ns/10ps
`default_nettype none
module io_port_bit #(
    parameter OPEN_DRAIN   = 0,
    parameter PULL_ANY_DIR = 0
) (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // control
    input  wire latchBit,
    input  wire dirBit,
    input  wire pullSel,
    // pin side
    output reg  pinOut,
    output reg  pinOe,
    output reg  pullEn
);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
            pullEn <= 1'b0;
        end else begin
            if (OPEN_DRAIN != 0) begin
                // only pulls low; a latched one leaves the pin floating [RQ8]
                pinOut <= 1'b0;
                pinOe  <= ~dirBit & ~latchBit; // [RQ8] [RQ12]
            end else begin
                pinOut <= latchBit; // [RQ16]
                pinOe  <= ~dirBit; // [RQ12]
            end
            if (PULL_ANY_DIR != 0)
                pullEn <= pullSel; // [RQ14]
            else
                pullEn <= pullSel & dirBit; // [RQ13] [RQ2] [RQ5]
        end
    end
endmodule // io_port_bit
`default_nettype wire

/* File: hdl/general_io_ports.v */
// general-purpose I/O ports with APB register access
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "general_io_ports_regs.vh"

// How it works
// RQ1: port A four pins, latch, per-bit direction
// RQ2: port A pull-ups as one group, inputs
// RQ3: reset makes port A all inputs
// RQ4: port B two pins, latch, per-bit direction
// RQ5: port B pull-ups as group, inputs only
// RQ6: reset makes port B all inputs
// RQ7: port C six pins, per-pin pull-ups
// RQ8: port D open drain, pulls low only
// RQ9: port D pull-ups fixed at build
// RQ10: mask build 16 pull-ups, flash 12
// RQ11: direction regs A-D, two pull-up regs
// RQ12: direction 0 output, 1 input
// RQ13: shared pull-up only on input bits
// RQ14: port C pull-up regardless of direction
// RQ15: port E four inputs, no driver
// RQ16: input reads pin, output drives latch
// RQ17: port E reads pins, writes ignored
module general_io_ports #(
    parameter MASK_VARIANT = 0,
    parameter FIXED_PULL_D = 4'h0
) (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // port A
    input  wire [3:0]  portAIn,
    output wire [3:0]  portAOut,
    output wire [3:0]  portAOe,
    output wire [3:0]  portAPull,
    // port B
    input  wire [1:0]  portBIn,
    output wire [1:0]  portBOut,
    output wire [1:0]  portBOe,
    output wire [1:0]  portBPull,
    // port C
    input  wire [5:0]  portCIn,
    output wire [5:0]  portCOut,
    output wire [5:0]  portCOe,
    output wire [5:0]  portCPull,
    // open-drain port D
    input  wire [3:0]  portDIn,
    output wire [3:0]  portDOut,
    output wire [3:0]  portDOe,
    output reg  [3:0]  portDPull,
    // input-only port E
    input  wire [3:0]  portEIn
);
    reg  [3:0] latchA_reg;
    reg  [1:0] latchB_reg;
    reg  [5:0] latchC_reg;
    reg  [3:0] latchD_reg;
    reg  [3:0] dirA_reg;
    reg  [1:0] dirB_reg;
    reg  [5:0] dirC_reg;
    reg  [3:0] dirD_reg;
    reg  [1:0] pullAb_reg;
    reg  [5:0] pullC_reg;
    reg  [31:0] rdata_next;
    reg        mapped_next;
    wire [3:0] syncA;
    wire [1:0] syncB;
    wire [5:0] syncC;
    wire [3:0] syncD;
    wire [3:0] syncE;
    wire [19:0] pinAll;
    wire [19:0] syncAll;
    wire       access;
    wire       wrStb;

    // pins pass two flops before any read
    assign pinAll = {portEIn, portDIn, portCIn, portBIn, portAIn};
    pin_sync #(.WIDTH(20)) u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .pinIn   (pinAll),
        .pinSync (syncAll)
    );
    assign syncA = syncAll[3:0];
    assign syncB = syncAll[5:4];
    assign syncC = syncAll[11:6];
    assign syncD = syncAll[15:12];
    assign syncE = syncAll[19:16];

    // mixes pin level and latch per direction bit
    function [7:0] mixRead;
        input [7:0] pins;
        input [7:0] latch;
        input [7:0] dir;
        begin
            mixRead = (pins & dir) | (latch & ~dir); // [RQ16]
        end
    endfunction

    // one-wait-state slave: setup, access with pready high
    assign access = psel & penable & ~pready;
    assign wrStb  = access & pwrite;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latchA_reg <= 4'h0;
            latchB_reg <= 2'h0;
            latchC_reg <= 6'h00;
            latchD_reg <= 4'h0;
            dirA_reg   <= 4'hF; // [RQ3]
            dirB_reg   <= 2'h3; // [RQ6]
            dirC_reg   <= 6'h3F;
            dirD_reg   <= 4'hF;
            pullAb_reg <= 2'h0;
            pullC_reg  <= 6'h00;
        end else if (wrStb) begin
            case (paddr)
                `ADDR_DATA_A:  latchA_reg <= pwdata[3:0]; // [RQ1]
                `ADDR_DATA_B:  latchB_reg <= pwdata[1:0]; // [RQ4]
                `ADDR_DATA_C:  latchC_reg <= pwdata[5:0]; // [RQ7]
                `ADDR_DATA_D:  latchD_reg <= pwdata[3:0]; // [RQ8]
                `ADDR_DIR_A:   dirA_reg   <= pwdata[3:0]; // [RQ1] [RQ11]
                `ADDR_DIR_B:   dirB_reg   <= pwdata[1:0]; // [RQ4] [RQ11]
                `ADDR_DIR_C:   dirC_reg   <= pwdata[5:0]; // [RQ7] [RQ11]
                `ADDR_DIR_D:   dirD_reg   <= pwdata[3:0]; // [RQ8] [RQ11]
                `ADDR_PULL_AB: pullAb_reg <= pwdata[1:0]; // [RQ11]
                `ADDR_PULL_C:  pullC_reg  <= pwdata[5:0]; // [RQ7] [RQ11]
                // port E write lands nowhere [RQ17]
                default: ;
            endcase
        end
    end

    // read mux; unused upper bits of direction registers read as ones
    always @* begin
        rdata_next  = 32'h0000_0000;
        mapped_next = 1'b1;
        case (paddr)
            `ADDR_DATA_A:  rdata_next[7:0] = mixRead({4'h0, syncA}, {4'h0, latchA_reg},
                                                     {4'h0, dirA_reg});
            `ADDR_DATA_B:  rdata_next[7:0] = mixRead({6'h00, syncB}, {6'h00, latchB_reg},
                                                     {6'h00, dirB_reg});
            `ADDR_DATA_C:  rdata_next[7:0] = mixRead({2'h0, syncC}, {2'h0, latchC_reg},
                                                     {2'h0, dirC_reg});
            `ADDR_DATA_D:  rdata_next[7:0] = mixRead({4'h0, syncD}, {4'h0, latchD_reg},
                                                     {4'h0, dirD_reg});
            `ADDR_DATA_E:  rdata_next[3:0] = syncE; // [RQ15] [RQ17]
            `ADDR_DIR_A:   rdata_next[7:0] = {4'hF, dirA_reg};
            `ADDR_DIR_B:   rdata_next[7:0] = {6'h3F, dirB_reg};
            `ADDR_DIR_C:   rdata_next[7:0] = {2'h3, dirC_reg};
            `ADDR_DIR_D:   rdata_next[7:0] = {4'hF, dirD_reg};
            `ADDR_PULL_AB: rdata_next[1:0] = pullAb_reg;
            `ADDR_PULL_C:  rdata_next[5:0] = pullC_reg;
            default:       mapped_next     = 1'b0;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped_next;
            if (access && !pwrite)
                prdata <= rdata_next;
        end
    end

    // pull-ups on port D only from the build option, mask variant only
    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            portDPull <= 4'h0;
        else
            portDPull <= (MASK_VARIANT != 0) ? FIXED_PULL_D : 4'h0; // [RQ9] [RQ10]
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_portA
            io_port_bit #(.OPEN_DRAIN(0), .PULL_ANY_DIR(0)) u_bit (
                .clk      (clk),
                .nrst     (nrst),
                .latchBit (latchA_reg[i]),
                .dirBit   (dirA_reg[i]),
                .pullSel  (pullAb_reg[`PULL_AB_BIT_A]), // [RQ2]
                .pinOut   (portAOut[i]),
                .pinOe    (portAOe[i]),
                .pullEn   (portAPull[i])
            );
        end
        for (i = 0; i < 2; i = i + 1) begin : g_portB
            io_port_bit #(.OPEN_DRAIN(0), .PULL_ANY_DIR(0)) u_bit (
                .clk      (clk),
                .nrst     (nrst),
                .latchBit (latchB_reg[i]),
                .dirBit   (dirB_reg[i]),
                .pullSel  (pullAb_reg[`PULL_AB_BIT_B]), // [RQ5]
                .pinOut   (portBOut[i]),
                .pinOe    (portBOe[i]),
                .pullEn   (portBPull[i])
            );
        end
        for (i = 0; i < 6; i = i + 1) begin : g_portC
            io_port_bit #(.OPEN_DRAIN(0), .PULL_ANY_DIR(1)) u_bit (
                .clk      (clk),
                .nrst     (nrst),
                .latchBit (latchC_reg[i]),
                .dirBit   (dirC_reg[i]),
                .pullSel  (pullC_reg[i]), // [RQ14]
                .pinOut   (portCOut[i]),
                .pinOe    (portCOe[i]),
                .pullEn   (portCPull[i])
            );
        end
        for (i = 0; i < 4; i = i + 1) begin : g_portD
            io_port_bit #(.OPEN_DRAIN(1), .PULL_ANY_DIR(0)) u_bit (
                .clk      (clk),
                .nrst     (nrst),
                .latchBit (latchD_reg[i]),
                .dirBit   (dirD_reg[i]),
                .pullSel  (1'b0),
                .pinOut   (portDOut[i]),
                .pinOe    (portDOe[i]),
                .pullEn   ()
            );
        end
    endgenerate
endmodule // general_io_ports
`default_nettype wire

/* File: verif/general_io_ports_properties.sv */
// assertion checker for the general I/O ports
`timescale 1ns/10ps
`default_nettype none
module io_ports_chk #(
    parameter MASK_VARIANT = 0
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // apb
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // pins
    input wire logic [3:0] portAOe,
    input wire logic [3:0] portAPull,
    input wire logic [1:0] portBOe,
    input wire logic [1:0] portBPull,
    input wire logic [3:0] portDOut,
    input wire logic [3:0] portDOe,
    input wire logic [3:0] portDPull
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_acc; psel && penable && !pready; endsequence
    sequence s_done; pready ##1 !pready; endsequence
    property p_answer; s_acc |=> s_done; endproperty
    a_answer: assert property (p_answer) else $error("pready not one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_odOut; portDOut == 4'h0; endproperty
    a_odOut: assert property (p_odOut) else $error("open-drain pin driven high");
    // pull-up is all or nothing over the input bits
    property p_pullA; portAPull == 4'h0 || portAPull == ~portAOe; endproperty
    a_pullA: assert property (p_pullA) else $error("port A pull wrong");
    property p_pullB; portBPull == 2'h0 || portBPull == ~portBOe; endproperty
    a_pullB: assert property (p_pullB) else $error("port B pull wrong");
    property p_odPull; MASK_VARIANT == 0 |-> portDPull == 4'h0; endproperty
    a_odPull: assert property (p_odPull) else $error("flash build has D pull");
    property p_rst; $rose(nrst) |-> portAOe == 4'h0 && portBOe == 2'h0 && portDOe == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("pin driven after reset");
    // drive may only change right after a completed access
    property p_oeCause; $changed(portAOe) |-> $past(pready); endproperty
    a_oeCause: assert property (p_oeCause) else $error("port A drive changed alone");
endmodule // io_ports_chk
bind general_io_ports io_ports_chk #(.MASK_VARIANT(MASK_VARIANT)) i_chk (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .portAOe(portAOe), .portAPull(portAPull), .portBOe(portBOe), .portBPull(portBPull),
    .portDOut(portDOut), .portDOe(portDOe), .portDPull(portDPull));
`default_nettype wire

/* File: verif/board_pins.sv */
// board model: resolves each pin from the port drive and the board drive
`timescale 1ns/10ps
`default_nettype none
module board_pins #(
    parameter W = 4
) (
    // clock
    input wire logic         clk,
    // port side
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pull,
    // board side
    input wire logic [W-1:0] extEn,
    input wire logic [W-1:0] extVal,
    output logic     [W-1:0] pin
);
    logic flt = 1'b0;
    // an undriven pin without pull-up wanders, so no check may rely on it
    always @(posedge clk) flt <= ~flt;
    always_comb
        for (int i = 0; i < W; i++)
            pin[i] = oe[i] ? out[i] : extEn[i] ? extVal[i] : pull[i] ? 1'b1 : flt;
endmodule // board_pins
`default_nettype wire

/* File: verif/general_io_ports_test.sv */
// self-checking testbench for the general I/O ports
`timescale 1ns/10ps
`default_nettype none
`include "general_io_ports_regs.vh"
module general_io_ports_test;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  portAIn, portAOut, portAOe, portAPull, portDIn, portDOut, portDOe, portDPull;
    logic [3:0]  portEIn, extA, extEnA, extEnD, extValD, pullMask;
    logic [1:0]  portBIn, portBOut, portBOe, portBPull, extEnB, extValB;
    logic [5:0]  portCIn, portCOut, portCOe, portCPull, extEnC, extValC;
    int          mismatches = 0;
    int          cmpCount = 0;

    general_io_ports i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
        .portAPull(portAPull), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
        .portBPull(portBPull), .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe),
        .portCPull(portCPull), .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe),
        .portDPull(portDPull), .portEIn(portEIn));
    // mask build: only its fixed port D pull-ups are looked at
    general_io_ports #(.MASK_VARIANT(1), .FIXED_PULL_D(4'h9)) i_dutMask (.clk(clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .portAIn(portAIn), .portAOut(),
        .portAOe(), .portAPull(), .portBIn(portBIn), .portBOut(), .portBOe(), .portBPull(),
        .portCIn(portCIn), .portCOut(), .portCOe(), .portCPull(), .portDIn(portDIn),
        .portDOut(), .portDOe(), .portDPull(pullMask), .portEIn(portEIn));
    board_pins #(.W(4)) i_pinA (.clk(clk), .out(portAOut), .oe(portAOe), .pull(portAPull),
        .extEn(extEnA), .extVal(extA), .pin(portAIn));
    board_pins #(.W(2)) i_pinB (.clk(clk), .out(portBOut), .oe(portBOe), .pull(portBPull),
        .extEn(extEnB), .extVal(extValB), .pin(portBIn));
    board_pins #(.W(6)) i_pinC (.clk(clk), .out(portCOut), .oe(portCOe), .pull(portCPull),
        .extEn(extEnC), .extVal(extValC), .pin(portCIn));
    board_pins #(.W(4)) i_pinD (.clk(clk), .out(portDOut), .oe(portDOe), .pull(portDPull),
        .extEn(extEnD), .extVal(extValD), .pin(portDIn));

    task automatic finalReport;
        if (mismatches == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                finalReport();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        extA = 4'h2;
        extEnA = 4'hF;
        extEnB = 2'h2;
        extValB = 2'h0;
        extEnC = 6'h0F;
        extValC = 6'h05;
        extEnD = 4'hF;
        extValD = 4'hC;
        portEIn = 4'h9;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        chk(32'({portAOe, portBOe, portCOe, portDOe}), 32'h0000_0000);
        xfer(1'b0, `ADDR_DIR_A, 32'h0000_0000);
        chk(32'(rd[7:0]), 32'h0000_00FF);
        xfer(1'b1, `ADDR_DATA_A, 32'h0000_0005);
        xfer(1'b1, `ADDR_DIR_A, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(32'({portAOe, portAOut}), 32'h0000_00F5);
        // mixed direction: pull lands only on the input bits
        xfer(1'b1, `ADDR_DIR_A, 32'h0000_000A);
        xfer(1'b1, `ADDR_PULL_AB, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(32'({portAOe, portAPull}), 32'h0000_005A);
        xfer(1'b0, `ADDR_DATA_A, 32'h0000_0000);
        chk(rd, 32'h0000_0007);
        xfer(1'b1, `ADDR_DIR_B, 32'h0000_0002);
        xfer(1'b1, `ADDR_PULL_AB, 32'h0000_0003);
        xfer(1'b1, `ADDR_DATA_B, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk(32'({portBOe, portBPull, portBOut[0]}), 32'h0000_000D);
        // board holds bit 1 low over the pull-up; bit 0 reads the latch
        xfer(1'b0, `ADDR_DATA_B, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        // port C keeps its pull-ups even while driving
        xfer(1'b1, `ADDR_PULL_C, 32'h0000_003F);
        xfer(1'b1, `ADDR_DIR_C, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(32'({portCOe, portCPull}), 32'h0000_0FFF);
        xfer(1'b1, `ADDR_DATA_C, 32'h0000_0030);
        xfer(1'b1, `ADDR_DIR_C, 32'h0000_000F);
        xfer(1'b0, `ADDR_DATA_C, 32'h0000_0000);
        chk(rd, 32'h0000_0035);
        xfer(1'b1, `ADDR_DATA_D, 32'h0000_0005);
        xfer(1'b1, `ADDR_DIR_D, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(32'({portDOe, portDOut, portDPull}), 32'h0000_0A00);
        chk(32'(pullMask), 32'h0000_0009);
        xfer(1'b1, `ADDR_DIR_D, 32'h0000_000F);
        xfer(1'b0, `ADDR_DATA_D, 32'h0000_0000);
        chk(rd, 32'h0000_000C);
        xfer(1'b1, `ADDR_DATA_E, 32'h0000_000F);
        xfer(1'b0, `ADDR_DATA_E, 32'h0000_0000);
        chk(rd, 32'h0000_0009);
        xfer(1'b1, 12'h100, 32'hFFFF_FFFF);
        chk(32'(err), 32'h0000_0001);
        xfer(1'b0, 12'h100, 32'h0000_0000);
        chk(32'({err, rd[30:0]}), 32'h8000_0000);
        finalReport();
    end
endmodule // general_io_ports_test
`default_nettype wire
